// >>> design/acs_pkg.sv
// Package of constants and types for the amplifier configuration and status registers.
package acs_pkg;

	// ============================================================
	// Register map and field positions
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MUTE = 8'h01;
	localparam logic [7:0] REG_SHDN = 8'h02;
	localparam logic [7:0] REG_CONFIG = 8'h03;
	localparam int CFG_MODE_BIT = 4;
	localparam int CFG_GAIN_BIT = 3;
	localparam int CFG_AUTO_DIS_BIT = 2;
	localparam int CFG_INPUT_BIT = 1;
	localparam logic [7:0] CFG_WRITE_MASK = 8'h1E;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] MUTE_WRITE_MASK = 8'h18;
	localparam logic [7:0] MUTE_RESET = 8'h00;
	localparam logic [7:0] SHDN_RESET = 8'h00;
	localparam logic [7:0] SHDN_WRITE_MASK = 8'h01;
	localparam logic [7:0] SHDN_RESET_ALL = 8'hFC;
	localparam int MUTE_LEFT_BIT = 3;
	localparam int MUTE_RIGHT_BIT = 4;
	localparam int SHDN_BIT = 0;
	localparam logic [1:0] SENSE_SETTLE = 2'h3;
	localparam int ST_THERM_BIT = 7;
	localparam int ST_MODE_BIT = 2;

	// ============================================================
	// Bus constants
	localparam logic [6:0] GENERAL_CALL = 7'h00;
	localparam logic [4:0] ADDR_UPPER = 5'h12;

	// ============================================================
	// Types
	typedef enum logic [2:0] {
		ACS_IDLE,
		ACS_ADDR,
		ACS_ACK,
		ACS_WRITE,
		ACS_READ,
		ACS_RACK
	} acs_state_t;

	typedef struct packed {
		logic overtemp;
		logic right_neg_overcurrent;
		logic right_pos_overcurrent;
		logic left_neg_overcurrent;
		logic left_pos_overcurrent;
	} acs_fault_t;

	typedef struct packed {
		logic headphone_mode;
		logic gain_b;
		logic input_2;
		logic right_neg_output_en;
		logic left_neg_output_en;
		logic output_stage_en;
		logic mute_left;
		logic mute_right;
		logic shutdown;
	} acs_amp_ctl_t;

endpackage

// >>> design/acs_regs.sv
// Serial slave port with configuration and status registers of the amplifier.
//
// Functional notes
// - Configuration bit 4 picks speaker (0, default) or headphone (1) mode when bit 2 is set.
// - Configuration bit 3 picks gain setting A (0, default) or B (1).
// - Configuration bit 2 set disables auto detection; sense input then ignored.
// - Configuration bit 1 picks input 1 (0, default) or input 2 (1).
// - On reads the device drives data after address ack, shifting out selected register.
// - Every register reads back, including read-only status at address zero.
// - Interrupt idles high, goes low when headphone sense changes while auto detection is on.
// - Interrupt stays low until master performs a read data operation.
// - Device acknowledges each received byte by pulling data low on ninth clock.
// - General call address is never acknowledged.
// - Only seven-bit addressing; no ten-bit formats are recognised.
// - Status bit 7 reads 1 while die is over the thermal limit.
// - Status bits 6 to 3 report the four output overcurrent conditions.
// - Status bit 2 reports present mode, 0 speaker, 1 headphone.
// - Auto detection in speaker mode forces gain setting A.
// - Headphone mode disables the inverting output of each bridged amplifier.
// - Output stage off above the thermal limit, back on after cooling 15 degrees.
// - Configuration register sits at address 03h, readable and writable.
`timescale 1ns/1ps
`default_nettype none

module acs_regs (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Address select strap bits
	input wire logic [1:0] addr_sel,
	// Analog status inputs
	input wire logic headphone_sense_in,
	input wire logic overtemp_trip,
	input wire logic overtemp_clear,
	input wire logic [3:0] overcurrent_in,
	// Outputs
	output logic int_n,
	output acs_pkg::acs_amp_ctl_t amp_ctl
);

	// ============================================================
	// Input synchronisers
	logic [1:0] scl_s_r, sda_s_r, hps_s_r, ott_s_r, otc_s_r;
	logic [3:0] oc_s1_r, oc_s2_r;
	logic scl_d_r, sda_d_r;
	logic [1:0] addr_sel_r;
	logic [1:0] addr_sel_s_r;

	// Bus lines reset to their idle high level, so no false edge follows reset.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			hps_s_r <= 2'h0;
			ott_s_r <= 2'h0;
			otc_s_r <= 2'h0;
			oc_s1_r <= 4'h0;
			oc_s2_r <= 4'h0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], scl_in};
			sda_s_r <= {sda_s_r[0], sda_in};
			hps_s_r <= {hps_s_r[0], headphone_sense_in};
			ott_s_r <= {ott_s_r[0], overtemp_trip};
			otc_s_r <= {otc_s_r[0], overtemp_clear};
			oc_s1_r <= overcurrent_in;
			oc_s2_r <= oc_s1_r;
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
		end
	end

	// The strap may be wired to a bus line, so it is synchronised like any other pin.
	always_ff @(posedge clk_sys) begin
		addr_sel_s_r <= addr_sel;
		addr_sel_r <= addr_sel_s_r;
	end

	logic scl, sda, scl_rise, scl_fall, start_cond, stop_cond;
	assign scl = scl_s_r[1];
	assign sda = sda_s_r[1];
	assign scl_rise = scl && !scl_d_r;
	assign scl_fall = !scl && scl_d_r;
	// Start and stop need the clock high on two samples, so a data change at a clock edge is ignored.
	assign start_cond = scl && scl_d_r && sda_d_r && !sda;
	assign stop_cond = scl && scl_d_r && !sda_d_r && sda;

	// ============================================================
	// Serial protocol engine
	acs_pkg::acs_state_t state_r;
	logic [7:0] shift_r, tx_r, ptr_r;
	logic [3:0] bit_cnt_r;
	logic is_read_r, have_ptr_r, addr_hit_r, read_done_r, wr_stb_r;
	logic [7:0] wr_data_r;
	logic [7:0] rd_data;
	logic [6:0] my_addr;
	assign my_addr = {acs_pkg::ADDR_UPPER, addr_sel_r};

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_r <= acs_pkg::ACS_IDLE;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			is_read_r <= 1'b0;
			have_ptr_r <= 1'b0;
			addr_hit_r <= 1'b0;
			read_done_r <= 1'b0;
			wr_stb_r <= 1'b0;
			wr_data_r <= 8'h00;
			sda_oe <= 1'b0;
		end else begin
			wr_stb_r <= 1'b0;
			read_done_r <= 1'b0;
			if (start_cond) begin
				state_r <= acs_pkg::ACS_ADDR;
				bit_cnt_r <= 4'h0;
				have_ptr_r <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state_r <= acs_pkg::ACS_IDLE;
				sda_oe <= 1'b0;
			end else begin
				unique case (state_r)
				acs_pkg::ACS_IDLE: begin
					sda_oe <= 1'b0;
				end
				acs_pkg::ACS_ADDR, acs_pkg::ACS_WRITE: begin
					// Data is taken on the rising clock edge, where the bus keeps it stable.
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == 4'h8) begin
						// Eight bits are in; the ninth clock is the acknowledge.
						bit_cnt_r <= 4'h0;
						if (state_r == acs_pkg::ACS_ADDR) begin
							// Seven-bit match only; general call never matches.
							if (shift_r[7:1] == my_addr && my_addr != acs_pkg::GENERAL_CALL) begin
								is_read_r <= shift_r[0];
								// The register is captured now, so its first bit is ready after the ack.
								tx_r <= rd_data;
								sda_oe <= 1'b1;
								state_r <= acs_pkg::ACS_ACK;
							end else begin
								state_r <= acs_pkg::ACS_IDLE;
							end
						end else begin
							// First byte is the pointer, the next is data.
							if (!have_ptr_r) begin
								ptr_r <= shift_r;
								have_ptr_r <= 1'b1;
							end else begin
								wr_data_r <= shift_r;
								wr_stb_r <= 1'b1;
							end
							sda_oe <= 1'b1;
							state_r <= acs_pkg::ACS_ACK;
						end
					end
				end
				acs_pkg::ACS_ACK: begin
					if (scl_fall) begin
						if (is_read_r) begin
							// Take over the line and shift out the selected register.
							sda_oe <= !tx_r[7];
							tx_r <= {tx_r[6:0], 1'b0};
							bit_cnt_r <= 4'h1;
							state_r <= acs_pkg::ACS_READ;
						end else begin
							sda_oe <= 1'b0;
							state_r <= acs_pkg::ACS_WRITE;
						end
					end
				end
				acs_pkg::ACS_READ: begin
					if (scl_fall) begin
						if (bit_cnt_r == 4'h8) begin
							sda_oe <= 1'b0;
							read_done_r <= 1'b1;
							state_r <= acs_pkg::ACS_RACK;
						end else begin
							sda_oe <= !tx_r[7];
							tx_r <= {tx_r[6:0], 1'b0};
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				acs_pkg::ACS_RACK: begin
					// A master ack repeats the same register; a nack ends the read.
					if (scl_rise) begin
						if (sda) begin
							state_r <= acs_pkg::ACS_IDLE;
						end else begin
							tx_r <= rd_data;
							is_read_r <= 1'b1;
						end
					end else if (scl_fall && !is_read_r) begin
						state_r <= acs_pkg::ACS_IDLE;
					end else if (scl_fall) begin
						sda_oe <= !tx_r[7];
						tx_r <= {tx_r[6:0], 1'b0};
						bit_cnt_r <= 4'h1;
						state_r <= acs_pkg::ACS_READ;
					end
				end
				default: begin
					// Unused state codes fall back to idle with the line released.
					state_r <= acs_pkg::ACS_IDLE;
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

	// The pin only ever pulls low; the enable alone decides whether it drives.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// ============================================================
	// Registers
	logic [7:0] cfg_r, mute_r, shdn_r;

	// A write lands one cycle after its data byte is taken, while the ack still stands.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cfg_r <= acs_pkg::CFG_RESET;
			mute_r <= acs_pkg::MUTE_RESET;
			shdn_r <= acs_pkg::SHDN_RESET;
		end else if (wr_stb_r) begin
			if (ptr_r == acs_pkg::REG_CONFIG) begin
				cfg_r <= wr_data_r & acs_pkg::CFG_WRITE_MASK;
			end else if (ptr_r == acs_pkg::REG_MUTE) begin
				mute_r <= wr_data_r & acs_pkg::MUTE_WRITE_MASK;
			end else if (ptr_r == acs_pkg::REG_SHDN) begin
				// Bits 7 to 2 all high return every register to its default.
				if ((wr_data_r & acs_pkg::SHDN_RESET_ALL) == acs_pkg::SHDN_RESET_ALL) begin
					cfg_r <= acs_pkg::CFG_RESET;
					mute_r <= acs_pkg::MUTE_RESET;
					shdn_r <= acs_pkg::SHDN_RESET;
				end else begin
					shdn_r <= wr_data_r & acs_pkg::SHDN_WRITE_MASK;
				end
			end
		end
	end

	// ============================================================
	// Mode, thermal and status
	logic auto_dis, hp_mode, thermal_r;
	assign auto_dis = cfg_r[acs_pkg::CFG_AUTO_DIS_BIT];
	assign hp_mode = auto_dis ? cfg_r[acs_pkg::CFG_MODE_BIT] : hps_s_r[1];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			thermal_r <= 1'b0;
		end else if (ott_s_r[1]) begin
			// Trip wins over clear, so the stage stays off while the die is still hot.
			thermal_r <= 1'b1;
		end else if (otc_s_r[1]) begin
			thermal_r <= 1'b0;
		end
	end

	acs_pkg::acs_fault_t faults;
	assign faults = {thermal_r, oc_s2_r};
	// Status bits 6 to 2 show live conditions; bit 7 holds a trip until clear, and the interrupt remembers an event.
	logic [7:0] status;
	assign status = {faults, hp_mode, 2'b00};

	// Unmapped addresses read as zero.
	always_comb begin
		unique case (ptr_r)
		acs_pkg::REG_STATUS: rd_data = status;
		acs_pkg::REG_MUTE: rd_data = mute_r;
		acs_pkg::REG_SHDN: rd_data = shdn_r;
		acs_pkg::REG_CONFIG: rd_data = cfg_r;
		default: rd_data = 8'h00;
		endcase
	end

	// ============================================================
	// Interrupt
	logic auto_detect_disable_r;
	logic [1:0] settle_r;

	// Edges are ignored until the sense chain has filled, so a headphone that is
	// already plugged in at reset does not look like an insertion.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			auto_detect_disable_r <= 1'b0;
			settle_r <= 2'h0;
			int_n <= 1'b1;
		end else begin
			auto_detect_disable_r <= hps_s_r[1];
			if (settle_r != acs_pkg::SENSE_SETTLE) begin
				settle_r <= settle_r + 2'h1;
			end
			// A new sense change wins over a read in the same cycle.
			if (settle_r == acs_pkg::SENSE_SETTLE && !auto_dis && hps_s_r[1] != auto_detect_disable_r) begin
				int_n <= 1'b0;
			end else if (read_done_r) begin
				int_n <= 1'b1;
			end
		end
	end

	// ============================================================
	// Amplifier control outputs
	// Every control output is registered, so the analog side sees clean levels.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			amp_ctl <= '0;
		end else begin
			amp_ctl.headphone_mode <= hp_mode;
			// Auto detection in speaker mode overrides the stored gain choice.
			amp_ctl.gain_b <= (!auto_dis && !hp_mode) ? 1'b0 : cfg_r[acs_pkg::CFG_GAIN_BIT];
			amp_ctl.input_2 <= cfg_r[acs_pkg::CFG_INPUT_BIT];
			amp_ctl.right_neg_output_en <= !hp_mode;
			amp_ctl.left_neg_output_en <= !hp_mode;
			amp_ctl.output_stage_en <= !thermal_r;
			amp_ctl.mute_left <= mute_r[acs_pkg::MUTE_LEFT_BIT];
			amp_ctl.mute_right <= mute_r[acs_pkg::MUTE_RIGHT_BIT];
			amp_ctl.shutdown <= shdn_r[acs_pkg::SHDN_BIT];
		end
	end

endmodule

`default_nettype wire

// >>> test/acs_regs_props.sv
// Port assertions for the amplifier register block.
`timescale 1ns/1ps
`default_nettype none
module acs_regs_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Straps and sensors
	input wire logic [1:0] addr_sel,
	input wire logic headphone_sense_in,
	input wire logic overtemp_trip,
	input wire logic overtemp_clear,
	input wire logic [3:0] overcurrent_in,
	// Outputs
	input wire logic int_n,
	input wire acs_pkg::acs_amp_ctl_t amp_ctl
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic sense_r;
	logic [3:0] age_r;
	// ============================================================
	// Cycles since the sense input last changed, saturating.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sense_r <= 1'b0;
			age_r <= 4'hF;
		end else begin
			sense_r <= headphone_sense_in;
			if (sense_r != headphone_sense_in) begin
				age_r <= 4'h0;
			end else if (age_r != 4'hF) begin
				age_r <= age_r + 4'h1;
			end
		end
	end
	sequence s_trip;
		$rose(overtemp_trip);
	endsequence
	sequence s_cool;
		$rose(overtemp_clear) && !overtemp_trip;
	endsequence
	AST_RESET_IDLE: assert property ($fell(reset) |-> int_n && !sda_oe)
		else $error("outputs not idle after reset");
	AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
		else $error("data line driven high");
	AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line changed while clock high");
	AST_INT_CAUSE: assert property ($fell(int_n) |-> age_r < 4'hC)
		else $error("interrupt without sense change");
	AST_INT_RELEASE: assert property ($rose(int_n) |-> !scl_in)
		else $error("interrupt released outside a read");
	AST_HP_NEG_OFF: assert property (amp_ctl.headphone_mode && $past(amp_ctl.headphone_mode)
		|-> !amp_ctl.right_neg_output_en && !amp_ctl.left_neg_output_en)
		else $error("inverting outputs on in headphone mode");
	AST_THERM_OFF: assert property (s_trip |-> ##[1:6] !amp_ctl.output_stage_en)
		else $error("output stage not off after trip");
	AST_THERM_ON: assert property (s_cool |-> ##[1:6] amp_ctl.output_stage_en)
		else $error("output stage not on after cooling");
endmodule
`default_nettype wire

// >>> test/acs_i2c_master.sv
// Bus master model driving the serial clock and pulling the data line.
`timescale 1ns/1ps
`default_nettype none
module acs_i2c_master (
	// Bus lines
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	localparam realtime QTR = 31.25;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		#QTR sda_low = 1'b0;
		#QTR scl = 1'b1;
		#QTR sda_low = 1'b1;
		#QTR scl = 1'b0;
	endtask
	task automatic stop();
		#QTR sda_low = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_low = 1'b0;
		#QTR;
	endtask
	// Eight bits first-out MSB and the ninth clock; each bit is sampled mid-high.
	task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] r,
		output logic ack);
		logic [8:0] w;
		w = {d, nak};
		for (int i = 8; i >= 0; i--) begin
			#QTR sda_low = !w[i];
			#QTR scl = 1'b1;
			#QTR w[i] = sda;
			#QTR scl = 1'b0;
		end
		r = w[8:1];
		ack = !w[0];
	endtask
endmodule
`default_nettype wire

// >>> test/test_acs_regs.sv
// Self-checking bench for the amplifier register block.
`timescale 1ns/1ps
`default_nettype none
module test_acs_regs;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic scl, m_low, sda_out, sda_oe, int_n, ack;
	logic [1:0] asel = 2'h0;
	logic hp = 1'b0;
	logic trip = 1'b0;
	logic clr = 1'b0;
	logic [3:0] oc = 4'h0;
	logic [7:0] rd_v, d;
	logic [31:0] rng = 32'hAC21;
	acs_pkg::acs_amp_ctl_t amp_ctl;
	int mismatches = 0;
	int tests_run = 0;
	int therm_m = 0;
	int cfg_m = 0;
	wire logic sda = (sda_oe ? sda_out : 1'b1) & ~m_low;
	acs_regs acs_regs_inst (.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(asel), .headphone_sense_in(hp),
		.overtemp_trip(trip), .overtemp_clear(clr), .overcurrent_in(oc), .int_n(int_n),
		.amp_ctl(amp_ctl));
	acs_i2c_master acs_i2c_master_inst (.scl(scl), .sda_low(m_low), .sda(sda));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		#350000;
		mismatches++;
		give_verdict();
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic xb(input logic [7:0] b, input logic nak, input logic exp_ack);
		acs_i2c_master_inst.xfer(b, nak, rd_v, ack);
		chk({7'h0, ack}, {7'h0, exp_ack}, "ack");
	endtask
	// Pointer write, then either one data byte or a repeated start and one read byte.
	task automatic acc(input logic [7:0] p, input logic [7:0] v, input logic rd);
		acs_i2c_master_inst.start();
		xb({acs_pkg::ADDR_UPPER, asel, 1'b0}, 1'b1, 1'b1);
		xb(p, 1'b1, 1'b1);
		if (rd) begin
			acs_i2c_master_inst.start();
			xb({acs_pkg::ADDR_UPPER, asel, 1'b1}, 1'b1, 1'b1);
			xb(8'hFF, 1'b1, 1'b0);
		end else begin
			xb(v, 1'b1, 1'b1);
		end
		acs_i2c_master_inst.stop();
	endtask
	task automatic st_chk();
		logic m;
		m = cfg_m[2] ? cfg_m[4] : hp;
		acc(acs_pkg::REG_STATUS, 8'h00, 1'b1);
		chk(rd_v, {therm_m[0], oc, m, 2'b00}, "status");
		chk({5'h0, amp_ctl.headphone_mode, amp_ctl.gain_b, amp_ctl.input_2},
			{5'h0, m, cfg_m[3] & (cfg_m[2] | m), cfg_m[1]}, "ctl");
		chk({2'h0, amp_ctl.right_neg_output_en, amp_ctl.left_neg_output_en,
			amp_ctl.output_stage_en, amp_ctl.mute_left, amp_ctl.mute_right, amp_ctl.shutdown},
			{2'h0, !m, !m, !therm_m[0], 3'h0}, "outputs");
	endtask
	task automatic give_verdict();
		$display("Checks run %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (6) @(posedge clk_sys);
		acc(acs_pkg::REG_CONFIG, 8'h00, 1'b1);
		chk(rd_v, 8'h00, "config reset");
		for (int i = 0; i < 8; i++) begin
			rng = xs(rng);
			d = {rng[7:4], i[2:0], rng[0]};
			@(posedge clk_sys);
			asel <= rng[9:8];
			hp <= rng[10];
			oc <= rng[14:11];
			acc(acs_pkg::REG_CONFIG, d, 1'b0);
			cfg_m = d & 8'h1E;
			acc(acs_pkg::REG_CONFIG, 8'h00, 1'b1);
			chk(rd_v, cfg_m[7:0], "config");
			st_chk();
		end
		// Sense change raises the interrupt only while auto detection is on.
		acc(acs_pkg::REG_CONFIG, 8'h00, 1'b0);
		cfg_m = 0;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			hp <= ~hp;
			repeat (200) @(posedge clk_sys);
			chk({7'h0, int_n}, {7'h0, cfg_m[2]}, "int low");
			st_chk();
			chk({7'h0, int_n}, 8'h01, "int released");
			acc(acs_pkg::REG_CONFIG, 8'h04, 1'b0);
			cfg_m = 4;
		end
		@(posedge clk_sys);
		trip <= 1'b1;
		repeat (10) @(posedge clk_sys);
		trip <= 1'b0;
		therm_m = 1;
		repeat (10) @(posedge clk_sys);
		chk({7'h0, amp_ctl.output_stage_en}, 8'h00, "stage off");
		st_chk();
		@(posedge clk_sys);
		clr <= 1'b1;
		therm_m = 0;
		repeat (10) @(posedge clk_sys);
		chk({7'h0, amp_ctl.output_stage_en}, 8'h01, "stage on");
		st_chk();
		// Mute keeps only its two bits; a reset-all write returns every register to default.
		acc(acs_pkg::REG_MUTE, 8'hFF, 1'b0);
		acc(acs_pkg::REG_MUTE, 8'h00, 1'b1);
		chk(rd_v, acs_pkg::MUTE_WRITE_MASK, "mute");
		acc(acs_pkg::REG_SHDN, 8'hFC, 1'b0);
		acc(acs_pkg::REG_CONFIG, 8'h00, 1'b1);
		chk(rd_v, acs_pkg::CFG_RESET, "config default");
		cfg_m = 0;
		st_chk();
		acs_i2c_master_inst.start();
		xb(8'h00, 1'b1, 1'b0);
		acs_i2c_master_inst.stop();
		acs_i2c_master_inst.start();
		xb({acs_pkg::ADDR_UPPER, ~asel, 1'b0}, 1'b1, 1'b0);
		acs_i2c_master_inst.stop();
		acc(8'h07, 8'h00, 1'b1);
		chk(rd_v, 8'h00, "unmapped");
		give_verdict();
	end
endmodule
bind acs_regs acs_regs_props acs_regs_props_inst (.clk_sys(clk_sys), .reset(reset),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
	.headphone_sense_in(headphone_sense_in), .overtemp_trip(overtemp_trip),
	.overtemp_clear(overtemp_clear), .overcurrent_in(overcurrent_in), .int_n(int_n),
	.amp_ctl(amp_ctl));
`default_nettype wire
